// ===== adcr_top.sv
/*
  Control, status and result logic of a 10-bit successive-approximation
  converter, reached over APB: triggering, prescaler, done flag and
  interrupt, result formatting with a read lock, pin input disable.
  Assumes the analog core presents its sample on analogSample when a
  conversion ends, and that peripheral flags arrive synchronous to clock.
*/
// The APB slave port was left to the implementer.
// Overview of operation
// (RULE1) Auto trigger starts conversion on source edge
// (RULE2) Done flag set when result registers load
// (RULE3) Interrupt request needs flag, enable, global enable
// (RULE4) Entering interrupt vector clears done flag
// (RULE5) Writing one clears done flag; zero keeps
// (RULE6) Divider codes give 2,2,4,8,16,32,64,128
// (RULE7) Result bytes right or left aligned, zeros elsewhere
// (RULE8) Low byte read locks results until high read
// (RULE9) Software reads low byte before high byte
// (RULE10) Trigger select ignored while auto trigger off
// (RULE11) Trigger is rising edge of source flag
// (RULE12) Switching to set source counts as edge
// (RULE13) Switching to free running never triggers
// (RULE14) Trigger codes map to eight fixed sources
// (RULE15) Software writes zero to control B top bit
// (RULE16) Disable bit blocks pin buffer, reads zero
// (RULE17) Start bit starts, reads busy, zero ignored
// (RULE18) First conversion 25 cycles; disabling aborts
// (RULE19) Triggers during a conversion are ignored
`timescale 1ns/1ns
module adcr_top #(
  parameter int RESULT_W = 10,
  parameter int PINS     = 8
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [RESULT_W-1:0] analogSample,
  input  wire logic [7:1]          triggerFlags,
  input  wire logic                globalIrqEnable,
  input  wire logic                vectorAck,
  input  wire logic [PINS-1:0]     pinRaw,
  output logic      [PINS-1:0]     pinRead,
  output logic      [PINS-1:0]     pinBufferOff,
  output logic                     convIrqReq,
  output logic                     irq
);

  logic [1:0]                 rstSync;
  logic                       rstN;
  adcr_pkg::adcr_req_t        req;
  logic                       acc;
  logic                       wrDone;
  logic                       rdDone;
  logic                       converterOn;
  logic                       autoTrig;
  logic                       doneFlag;
  logic                       irqEnable;
  logic [2:0]                 divSel;
  logic [2:0]                 trigSel;
  logic [2:0]                 prevTrigSel;
  logic                       leftAlign;
  logic [PINS-1:0]            pinDisable;
  logic [adcr_pkg::IRQ_BITS-1:0] irqStatus;
  logic [adcr_pkg::IRQ_BITS-1:0] irqMask;
  logic [RESULT_W-1:0]        result;
  logic                       locked;
  adcr_pkg::adcr_state_t      state;
  logic                       firstPending;
  logic                       firstConv;
  logic [6:0]                 presc;
  logic                       tick;
  logic [4:0]                 convCount;
  logic                       lastStep;
  logic                       loadResult;
  logic                       selFlag;
  logic                       prevSelFlag;
  logic                       trigEdge;
  logic                       writeStart;
  logic                       startConv;
  logic                       dropTrig;
  logic [7:0]                 lowView;
  logic [7:0]                 highView;
  logic [7:0]                 readByte;
  logic                       readHit;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and request decode

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  function automatic logic hitIndex(input logic [11:0] addr, input logic [7:0] idx);
    hitIndex = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (addr[9:2] == idx);
  endfunction

  assign req.index = paddr[9:2];
  assign req.write = pwrite;
  assign req.data  = pwdata[7:0];
  assign acc    = psel && penable && pready;
  assign wrDone = acc && req.write;
  assign rdDone = acc && !req.write;

  ////////////////////////////////////////////////////////////////////////
  // Result views; byte lanes not carrying result bits read zero

  always_comb begin
    if (leftAlign) begin
      highView = result[9:2];                                       // RULE7
      lowView  = {result[1:0], 6'h00};                              // RULE7
    end else begin
      highView = {6'h00, result[9:8]};                              // RULE7
      lowView  = result[7:0];                                       // RULE7
    end
  end

  always_comb begin
    readByte = 8'h00;
    readHit  = 1'b1;
    if (hitIndex(paddr, adcr_pkg::IDX_RESULT_LOW)) begin
      readByte = lowView;
    end else if (hitIndex(paddr, adcr_pkg::IDX_RESULT_HIGH)) begin
      readByte = highView;
    end else if (hitIndex(paddr, adcr_pkg::IDX_CONTROL_A)) begin
      readByte = {converterOn, state == adcr_pkg::ADCR_CONVERT, autoTrig,
                  doneFlag, irqEnable, divSel};                     // RULE17
    end else if (hitIndex(paddr, adcr_pkg::IDX_CONTROL_B)) begin
      readByte = {5'h00, trigSel};
    end else if (hitIndex(paddr, adcr_pkg::IDX_FORMAT)) begin
      readByte = {2'h0, leftAlign, 5'h00};
    end else if (hitIndex(paddr, adcr_pkg::IDX_PIN_DISABLE)) begin
      readByte = pinDisable;
    end else if (hitIndex(paddr, adcr_pkg::IDX_IRQ_STATUS)) begin
      readByte = {5'h00, irqStatus};
    end else if (hitIndex(paddr, adcr_pkg::IDX_IRQ_MASK)) begin
      readByte = {5'h00, irqMask};
    end else begin
      readHit = 1'b0;
    end
  end

  // One wait state: the answer comes on the second access cycle
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !readHit;
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h000000, readByte}
                                                         : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      converterOn <= 1'b0;
      autoTrig    <= 1'b0;
      irqEnable   <= 1'b0;
      divSel      <= 3'h0;
      trigSel     <= 3'h0;
      leftAlign   <= 1'b0;
      pinDisable  <= adcr_pkg::RESET_BYTE;
      irqMask     <= 3'h0;
    end else if (wrDone) begin
      if (hitIndex(paddr, adcr_pkg::IDX_CONTROL_A)) begin
        converterOn <= req.data[adcr_pkg::CA_ON];
        autoTrig    <= req.data[adcr_pkg::CA_AUTO];
        irqEnable   <= req.data[adcr_pkg::CA_IRQ_EN];
        divSel      <= req.data[adcr_pkg::CA_DIV_LSB +: 3];
      end else if (hitIndex(paddr, adcr_pkg::IDX_CONTROL_B)) begin
        trigSel <= req.data[adcr_pkg::CB_TSEL_LSB +: 3];            // RULE15
      end else if (hitIndex(paddr, adcr_pkg::IDX_FORMAT)) begin
        leftAlign <= req.data[adcr_pkg::FMT_LEFT];
      end else if (hitIndex(paddr, adcr_pkg::IDX_PIN_DISABLE)) begin
        pinDisable <= req.data;
      end else if (hitIndex(paddr, adcr_pkg::IDX_IRQ_MASK)) begin
        irqMask <= req.data[2:0];
      end
    end
  end

  assign writeStart = wrDone && hitIndex(paddr, adcr_pkg::IDX_CONTROL_A)
                      && req.data[adcr_pkg::CA_START] && req.data[adcr_pkg::CA_ON];

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: one-cycle tick at the converter clock rate

  function automatic logic [6:0] divLimit(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: divLimit = 7'h01;
      3'h2:       divLimit = 7'h03;
      3'h3:       divLimit = 7'h07;
      3'h4:       divLimit = 7'h0F;
      3'h5:       divLimit = 7'h1F;
      3'h6:       divLimit = 7'h3F;
      default:    divLimit = 7'h7F;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      presc <= 7'h00;
    end else if (!converterOn || presc >= divLimit(divSel)) begin
      presc <= 7'h00;                                               // RULE6
    end else begin
      presc <= presc + 7'h01;
    end
  end
  assign tick = converterOn && (presc >= divLimit(divSel));         // RULE6

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection and edge detection

  always_comb begin
    case (trigSel)                                                  // RULE14
      3'h0:    selFlag = doneFlag;
      default: selFlag = triggerFlags[trigSel];
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prevSelFlag <= 1'b0;
      prevTrigSel <= 3'h0;
    end else begin
      prevSelFlag <= selFlag;
      prevTrigSel <= trigSel;
    end
  end

  // Edge of whatever is selected now, so a source swap can fire too
  assign trigEdge = selFlag && !prevSelFlag                         // RULE11 RULE12
                    && !(trigSel == adcr_pkg::TSEL_FREE
                         && prevTrigSel != adcr_pkg::TSEL_FREE);    // RULE13
  // A start written together with the enable bit must not wait for it to land
  assign startConv = state == adcr_pkg::ADCR_IDLE                   // RULE17
                     && (writeStart || (converterOn && autoTrig && trigEdge)); // RULE1 RULE10
  assign dropTrig  = autoTrig && trigEdge && state == adcr_pkg::ADCR_CONVERT; // RULE19

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  assign lastStep = tick && (convCount == (firstConv ? 5'(adcr_pkg::FIRST_CYCLES - 1)
                                                     : 5'(adcr_pkg::NORMAL_CYCLES - 1)));
  assign loadResult = state == adcr_pkg::ADCR_CONVERT && lastStep && !locked;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      firstPending <= 1'b1;
    end else if (startConv) begin
      firstPending <= 1'b0;
    end else if (!converterOn) begin
      firstPending <= 1'b1;                                         // RULE18
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state     <= adcr_pkg::ADCR_IDLE;
      convCount <= 5'h00;
      firstConv <= 1'b0;
    end else begin
      case (state)
        adcr_pkg::ADCR_IDLE: begin
          if (startConv) begin
            state     <= adcr_pkg::ADCR_CONVERT;
            convCount <= 5'h00;
            firstConv <= firstPending;                              // RULE18
          end
        end
        default: begin
          if (!converterOn || lastStep) begin
            state <= adcr_pkg::ADCR_IDLE;                           // RULE18 RULE17
          end else if (tick) begin
            convCount <= convCount + 5'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result register and read lock

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      result <= '0;
    end else if (loadResult) begin
      result <= analogSample;                                       // RULE2 RULE8
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      locked <= 1'b0;
    end else if (rdDone && hitIndex(paddr, adcr_pkg::IDX_RESULT_LOW)) begin
      locked <= 1'b1;                                               // RULE8 RULE9
    end else if (rdDone && hitIndex(paddr, adcr_pkg::IDX_RESULT_HIGH)) begin
      locked <= 1'b0;                                               // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Done flag and interrupts; a setting event wins over any clear

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      doneFlag <= 1'b0;
    end else if (loadResult) begin
      doneFlag <= 1'b1;                                             // RULE2
    end else if (vectorAck) begin
      doneFlag <= 1'b0;                                             // RULE4
    end else if (wrDone && hitIndex(paddr, adcr_pkg::IDX_CONTROL_A)
                 && req.data[adcr_pkg::CA_DONE]) begin
      doneFlag <= 1'b0;                                             // RULE5
    end
  end

  generate
    for (genvar i = 0; i < adcr_pkg::IRQ_BITS; i++) begin : g_status
      logic setBit;
      assign setBit = (i == adcr_pkg::IRQ_DONE)    ? loadResult :
                      (i == adcr_pkg::IRQ_DROPPED) ? dropTrig   :
                      (state == adcr_pkg::ADCR_CONVERT && lastStep && locked);
      always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
          irqStatus[i] <= 1'b0;
        end else if (setBit) begin
          irqStatus[i] <= 1'b1;
        end else if (wrDone && hitIndex(paddr, adcr_pkg::IDX_IRQ_STATUS) && req.data[i]) begin
          irqStatus[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      convIrqReq <= 1'b0;
      irq        <= 1'b0;
    end else begin
      convIrqReq <= doneFlag && irqEnable && globalIrqEnable;       // RULE3
      irq        <= |(irqStatus & irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin digital input disable

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pinRead      <= '0;
      pinBufferOff <= '0;
    end else begin
      pinRead      <= pinRaw & ~pinDisable;                         // RULE16
      pinBufferOff <= pinDisable;                                   // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] tickGap;
  logic [2:0] gapDiv;
  logic       gapArmed;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tickGap  <= 8'h00;
      gapDiv   <= 3'h0;
      gapArmed <= 1'b0;
    end else if (!converterOn || gapDiv != divSel) begin
      // A gap spanning a divider change or an off period proves nothing
      tickGap  <= 8'h00;
      gapDiv   <= divSel;
      gapArmed <= 1'b0;
    end else begin
      tickGap  <= tick ? 8'h01 : tickGap + 8'h01;
      gapArmed <= gapArmed || tick;
    end
  end

  sequence s_startIdle;
    converterOn && state == adcr_pkg::ADCR_IDLE && autoTrig && trigEdge;
  endsequence
  sequence s_enterConvert;
    ##1 state == adcr_pkg::ADCR_CONVERT;
  endsequence

  property p_autoStart;
    @(posedge clock) disable iff (!rstN) s_startIdle |-> s_enterConvert;
  endproperty
  a_autoStart: assert property (p_autoStart) else $error("auto trigger missed"); // RULE1

  property p_doneOnLoad;
    @(posedge clock) disable iff (!rstN) loadResult |=> doneFlag && result == $past(analogSample);
  endproperty
  a_doneOnLoad: assert property (p_doneOnLoad) else $error("flag or result wrong"); // RULE2

  property p_irqReq;
    @(posedge clock) disable iff (!rstN)
      ##1 convIrqReq == $past(doneFlag && irqEnable && globalIrqEnable);
  endproperty
  a_irqReq: assert property (p_irqReq) else $error("irq request mismatch"); // RULE3

  property p_vectorClear;
    @(posedge clock) disable iff (!rstN) vectorAck && !loadResult |=> !doneFlag;
  endproperty
  a_vectorClear: assert property (p_vectorClear) else $error("vector left flag"); // RULE4

  property p_w1c;
    @(posedge clock) disable iff (!rstN)
      wrDone && hitIndex(paddr, adcr_pkg::IDX_CONTROL_A) && !loadResult && !vectorAck
      |=> doneFlag == ($past(doneFlag) && !$past(req.data[adcr_pkg::CA_DONE]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag write wrong"); // RULE5

  property p_tickRate;
    @(posedge clock) disable iff (!rstN)
      tick && gapArmed && converterOn && gapDiv == divSel
      |-> tickGap == 8'(divLimit(divSel)) + 8'h01;
  endproperty
  a_tickRate: assert property (p_tickRate) else $error("divider rate wrong"); // RULE6

  property p_format;
    @(posedge clock) disable iff (!rstN)
      leftAlign |-> {highView, lowView[7:6]} == result && lowView[5:0] == 6'h00;
  endproperty
  a_format: assert property (p_format) else $error("left alignment wrong"); // RULE7

  property p_lockHold;
    @(posedge clock) disable iff (!rstN) locked |=> $stable(result);
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("locked result changed"); // RULE8

  property p_noAuto;
    @(posedge clock) disable iff (!rstN)
      state == adcr_pkg::ADCR_IDLE && !autoTrig && !writeStart
      |=> state == adcr_pkg::ADCR_IDLE;
  endproperty
  a_noAuto: assert property (p_noAuto) else $error("start without cause"); // RULE10

  property p_freeSwitch;
    @(posedge clock) disable iff (!rstN)
      trigSel == adcr_pkg::TSEL_FREE && prevTrigSel != adcr_pkg::TSEL_FREE |-> !trigEdge;
  endproperty
  a_freeSwitch: assert property (p_freeSwitch) else $error("free mode fired"); // RULE13

  property p_abort;
    @(posedge clock) disable iff (!rstN)
      !converterOn && !writeStart |=> state == adcr_pkg::ADCR_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed"); // RULE18

  property p_ignoreBusy;
    @(posedge clock) disable iff (!rstN)
      dropTrig && !lastStep && converterOn |=> state == adcr_pkg::ADCR_CONVERT
      && convCount >= $past(convCount);
  endproperty
  a_ignoreBusy: assert property (p_ignoreBusy) else $error("busy trigger restarted"); // RULE19

  property p_pins;
    @(posedge clock) disable iff (!rstN) ##1 pinRead == $past(pinRaw & ~pinDisable);
  endproperty
  a_pins: assert property (p_pins) else $error("pin read wrong"); // RULE16

endmodule

// ===== adcr_pkg.sv
/*
  Package for the converter control and result block: register indices,
  field positions, reset values, timing counts and shared types.
  Assumes a 32-bit APB slave where every register takes one aligned word.
*/
package adcr_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CONTROL_A   = 8'h7A;
  localparam logic [7:0] IDX_CONTROL_B   = 8'h7B;
  localparam logic [7:0] IDX_FORMAT      = 8'h7C;
  localparam logic [7:0] IDX_PIN_DISABLE = 8'h7E;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h80;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h81;

  // Control A fields
  localparam int CA_ON       = 7;
  localparam int CA_START    = 6;
  localparam int CA_AUTO     = 5;
  localparam int CA_DONE     = 4;
  localparam int CA_IRQ_EN   = 3;
  localparam int CA_DIV_LSB  = 0;
  // Control B and format fields
  localparam int CB_TSEL_LSB = 0;
  localparam int FMT_LEFT    = 5;
  // Interrupt status bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_DROPPED = 1;
  localparam int IRQ_LOST    = 2;
  localparam int IRQ_BITS    = 3;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] TSEL_FREE  = 3'h0;

  // Converter clock counts per conversion
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES  = 25;

  typedef enum logic [0:0] {
    ADCR_IDLE    = 1'b0,
    ADCR_CONVERT = 1'b1
  } adcr_state_t;

  typedef struct packed {
    logic [7:0]  index;
    logic        write;
    logic [7:0]  data;
  } adcr_req_t;

endpackage

// ===== adcr_top_bench.sv
/*
  Self-checking bench for adcr_top: registers over APB, conversion timing,
  triggers, result lock, interrupts and pin input disable.
  Assumes the bench stands in for the analog core, the processor and the pins.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module adcr_top_bench;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        globalIrqEnable, vectorAck, convIrqReq, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0]  analogSample, res;
  logic [7:1]  triggerFlags;
  logic [7:0]  pinRaw, pinRead, pinBufferOff, dis;
  int          failures, n_checks, cycles, dv;
  logic [7:0]  regs [8] = '{adcr_pkg::IDX_RESULT_LOW, adcr_pkg::IDX_RESULT_HIGH,
    adcr_pkg::IDX_CONTROL_A, adcr_pkg::IDX_CONTROL_B, adcr_pkg::IDX_FORMAT,
    adcr_pkg::IDX_PIN_DISABLE, adcr_pkg::IDX_IRQ_STATUS, adcr_pkg::IDX_IRQ_MASK};

  adcr_top i_dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analogSample(analogSample), .triggerFlags(triggerFlags),
    .globalIrqEnable(globalIrqEnable), .vectorAck(vectorAck), .pinRaw(pinRaw),
    .pinRead(pinRead), .pinBufferOff(pinBufferOff), .convIrqReq(convIrqReq), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // An idle cycle between transfers keeps every signal to one driver per step
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d, q, err);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00, q, err);
    `CHK(q, {24'h0, exp})
  endtask

  task automatic result(input logic left);
    logic [15:0] x;
    x = left ? {res, 6'h00} : {6'h00, res};
    rdc(adcr_pkg::IDX_RESULT_LOW, x[7:0]);
    rdc(adcr_pkg::IDX_RESULT_HIGH, x[15:8]);
  endtask

  task automatic waitIrq(input int lo, input int hi, input logic [7:0] st);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    rdc(adcr_pkg::IDX_IRQ_STATUS, st);
    wr(adcr_pkg::IDX_IRQ_STATUS, 8'h07);
  endtask

  task automatic convert(input logic [7:0] ctl, input int lo, input int hi,
                         input logic [7:0] st);
    analogSample <= res;
    wr(adcr_pkg::IDX_CONTROL_A, ctl);
    waitIrq(lo, hi, st);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(adcr_pkg::IDX_CONTROL_A, 1'b0, 8'h00, q, err);
      n++;
    end while (q[6] !== 1'b0 && n < 200);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, globalIrqEnable, vectorAck, arst_n} = '0;
    {paddr, pwdata, analogSample, triggerFlags, pinRaw, res} = '0;
    dv = $urandom(32'h70C375C6);
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (regs[i]) rdc(regs[i], 8'h00);
    apb(8'h7D, 1'b0, 8'h00, q, err);
    `CHK({err, q}, 33'h100000000)
    apb(8'h7F, 1'b1, 8'hFF, q, err);
    `CHK(err, 1'b1)
    pinRaw <= 8'($urandom);
    dis = 8'($urandom);
    wr(adcr_pkg::IDX_PIN_DISABLE, dis);
    rdc(adcr_pkg::IDX_PIN_DISABLE, dis);
    `CHK(pinBufferOff, dis)
    `CHK(pinRead, pinRaw & ~dis)
    wr(adcr_pkg::IDX_IRQ_MASK, 8'h05);
    // Code 0 is also the first conversion after enable, so it gets 25 ticks
    for (int c = 0; c < 8; c++) begin
      dv = (c < 2) ? 2 : (1 << c);
      res = 10'($urandom);
      convert(8'hC0 | 8'(c), (c == 0 ? 24 : 12) * dv, (c == 0 ? 25 : 13) * dv + 8, 8'h01);
      rdc(adcr_pkg::IDX_CONTROL_A, 8'h90 | 8'(c));
      result(1'b0);
    end
    apb(adcr_pkg::IDX_RESULT_LOW, 1'b0, 8'h00, q, err);
    analogSample <= ~res;
    wr(adcr_pkg::IDX_CONTROL_A, 8'hC0);
    waitIrq(24, 34, 8'h04);
    rdc(adcr_pkg::IDX_RESULT_HIGH, {6'h00, res[9:8]});
    res = 10'($urandom);
    convert(8'hC0, 24, 34, 8'h01);
    wr(adcr_pkg::IDX_FORMAT, 8'h20);
    result(1'b1);
    wr(adcr_pkg::IDX_FORMAT, 8'h00);
    wr(adcr_pkg::IDX_CONTROL_A, 8'h80);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'h90);
    wr(adcr_pkg::IDX_CONTROL_A, 8'h90);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'h80);
    convert(8'hC8, 24, 34, 8'h01);
    `CHK(convIrqReq, 1'b0)
    globalIrqEnable <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(convIrqReq, 1'b1)
    vectorAck <= 1'b1;
    @(posedge clock);
    vectorAck <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(convIrqReq, 1'b0)
    rdc(adcr_pkg::IDX_CONTROL_A, 8'h88);
    globalIrqEnable <= 1'b0;
    wr(adcr_pkg::IDX_IRQ_MASK, 8'h00);
    wr(adcr_pkg::IDX_CONTROL_A, 8'hC0);
    idle();
    `CHK(irq, 1'b0)
    rdc(adcr_pkg::IDX_IRQ_STATUS, 8'h01);
    wr(adcr_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b1)
    wr(adcr_pkg::IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(adcr_pkg::IDX_IRQ_MASK, 8'h05);
    wr(adcr_pkg::IDX_CONTROL_A, 8'hC7);
    wr(adcr_pkg::IDX_CONTROL_A, 8'h00);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'h10);
    res = 10'($urandom);
    convert(8'hC0, 48, 58, 8'h01);
    result(1'b0);
    wr(adcr_pkg::IDX_CONTROL_B, 8'h03);
    triggerFlags <= 7'h04;
    repeat (2) @(posedge clock);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'h90);
    triggerFlags <= 7'h00;
    for (int k = 1; k < 8; k++) begin
      wr(adcr_pkg::IDX_CONTROL_B, 8'(k));
      wr(adcr_pkg::IDX_CONTROL_A, 8'hA0);
      triggerFlags[k] <= 1'b1;
      rdc(adcr_pkg::IDX_CONTROL_A, 8'hF0);
      triggerFlags[k] <= 1'b0;
      @(posedge clock);
      triggerFlags[k] <= 1'b1;
      waitIrq(5, 40, 8'h03);
      rdc(adcr_pkg::IDX_CONTROL_A, 8'hB0);
      triggerFlags[k] <= 1'b0;
    end
    // Source 2 already set, source 1 clear: the swap alone must fire
    wr(adcr_pkg::IDX_CONTROL_B, 8'h01);
    triggerFlags <= 7'h02;
    wr(adcr_pkg::IDX_CONTROL_B, 8'h02);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'hF0);
    waitIrq(5, 40, 8'h01);
    // Flag low first, so only the suppression keeps the set done flag from firing
    triggerFlags <= 7'h00;
    wr(adcr_pkg::IDX_CONTROL_B, 8'h00);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'hB0);
    // Free running: the conversion's own done flag starts the next one
    wr(adcr_pkg::IDX_CONTROL_A, 8'hF0);
    waitIrq(24, 34, 8'h01);
    rdc(adcr_pkg::IDX_CONTROL_A, 8'hF0);
    wr(adcr_pkg::IDX_CONTROL_A, 8'h80);
    finish_test();
  end
endmodule
